// file: src/time_pulse_stamper.sv
// Purpose: local time scale, pulse output and edge stamping
// Assumes: lte_lock level and gnss_pulse from outside, synchronised here
// Notes:   one report register, later reports overwrite earlier ones
//
// How it works
// - Three host-chosen modes: pulse train, single stamped pulse, input stamps.
// - Stamp of a generated pulse is the time at its rising edge.
// - Time comes from navigation pulses or base-station lock, by availability.
// - Every timing source change raises a status report, unless a REG_CTRL write lands in the same cycle.
// - Reports only go out once the host has enabled them.
// - Report word carries operation, source, UTC flag and step result.
// - On UTC alignment the jump of local time is reported.
// - Offset in nanoseconds and seconds shifts pulses and stamps.
// - Writing both offset parts zero removes any offset.
// - Start reports initialisation with the mode number as operation.
// - On base-station lock, pulses start on local scale, code 4,2,0,0.
// - Navigation pulses align to UTC, code 4,1,1,0, then 4,1,1,1.
// - Losing navigation falls back to base station, code 4,2,1,0.
// - Stop ends pulses and stamps, while the base time scale runs on, and reports code 0,3,1,0.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module time_pulse_stamper #(
  parameter logic [stamper_pkg::PCNT_W-1:0] PULSE_CYC =
    stamper_pkg::PCNT_W'(stamper_pkg::PULSE_CYC_DEF),
  parameter logic [stamper_pkg::GCNT_W-1:0] GNSS_LOSS_CYC =
    stamper_pkg::GCNT_W'(stamper_pkg::GNSS_LOSS_DEF)
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        gnss_pulse,
  input  wire logic        lte_lock,
  input  wire logic        ext_edge,
  output logic             pulse_out,
  output logic             irq
);
  import stamper_pkg::*;

  // ******************************
  // State
  // ******************************
  typedef struct packed {
    logic [3:0]  gp;
    logic [3:0]  ll;
    logic [3:0]  ex;
    logic        gp_d;
    logic        ex_d;
    state_t      fsm;
    logic [1:0]  mode;
    logic        sten;
    logic        shot_arm;
    logic [29:0] ns;
    logic [31:0] sec;
    logic [29:0] off_ns;
    logic [31:0] off_s;
    logic [31:0] rpt;
    logic [29:0] disc;
    logic [29:0] ts_ns;
    logic [31:0] ts_s;
    logic [2:0]  ist;
    logic [2:0]  imask;
    logic        irq;
    logic [GCNT_W-1:0] gcnt;
    logic [PCNT_W-1:0] pcnt;
    logic        pout;
    logic        awrdy;
    logic        wrdy;
    logic        bvld;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvld;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  awa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        aw_ok;
    logic        w_ok;
  } st_t;

  st_t         r_reg;
  st_t         r_next;
  logic [29:0] adj_ns;
  logic [31:0] adj_s;
  logic        gp_rise;
  logic        ex_rise;
  logic        running;
  logic        fire;
  logic        wr_go;
  logic [30:0] sum_ns;

  // ******************************
  // Offset-shifted view of time
  // ******************************
  // The offset is applied on the way out, so an offset write never moves the base scale
  assign sum_ns = {1'b0, r_reg.ns} + {1'b0, r_reg.off_ns};
  assign adj_ns = (sum_ns >= {1'b0, NS_PER_SEC}) ?
                  30'(sum_ns - {1'b0, NS_PER_SEC}) : sum_ns[29:0];
  assign adj_s  = r_reg.sec + r_reg.off_s +
                  {31'h0, sum_ns >= {1'b0, NS_PER_SEC}};
  assign gp_rise = r_reg.gp[3] & ~r_reg.gp_d;
  assign ex_rise = r_reg.ex[3] & ~r_reg.ex_d;
  assign running = r_reg.fsm inside {ST_LOCAL, ST_DISC, ST_UTC, ST_HOLD};
  // First cycle of each shifted second
  assign fire = running && (adj_ns < NS_STEP) &&
                (r_reg.mode == MODE_PPS ||
                 (r_reg.mode == MODE_SHOT && r_reg.shot_arm));
  assign wr_go = r_reg.aw_ok & r_reg.w_ok & ~r_reg.bvld;

  // ******************************
  // Next state
  // ******************************
  always_comb begin
    logic [31:0] m;
    logic [31:0] rp;
    logic        rv;
    logic [2:0]  set;
    m = '0;
    rp = '0;
    rv = 1'b0;
    set = '0;
    r_next = r_reg;
    // Three-flop pin synchronisers
    r_next.gp = sync3(r_reg.gp, gnss_pulse);
    r_next.ll = sync3(r_reg.ll, lte_lock);
    r_next.ex = sync3(r_reg.ex, ext_edge);
    r_next.gp_d = r_reg.gp[3];
    r_next.ex_d = r_reg.ex[3];
    // Free-running base time scale
    r_next.ns = r_reg.ns + NS_STEP;
    if (r_next.ns >= NS_PER_SEC) begin
      r_next.ns = r_next.ns - NS_PER_SEC;
      r_next.sec = r_reg.sec + 32'h1;
    end
    // Source tracking; gnss edges snap the scale to a whole second
    case (r_reg.fsm)
      ST_IDLE: begin
      end
      ST_INIT: if (r_reg.ll[3]) begin
        r_next.fsm = ST_LOCAL;
        rv = 1'b1;
        rp = rpt_word(OP_RUN, SRC_LTE, 1'b0, 1'b0);
        set[IRQ_SRC] = 1'b1;
      end
      ST_LOCAL, ST_HOLD: if (gp_rise) begin
        r_next.fsm = ST_DISC;
        r_next.disc = r_reg.ns;
        r_next.ns = '0;
        if (r_reg.ns >= NS_HALF) r_next.sec = r_reg.sec + 32'h1;
        r_next.gcnt = '0;
        rv = 1'b1;
        rp = rpt_word(OP_RUN, SRC_GNSS, 1'b1, 1'b0);
        set[IRQ_SRC] = 1'b1;
      end
      ST_DISC: begin
        r_next.fsm = ST_UTC;
        rv = 1'b1;
        rp = rpt_word(OP_RUN, SRC_GNSS, 1'b1, 1'b1);
      end
      ST_UTC: if (gp_rise) begin
        r_next.ns = '0;
        if (r_reg.ns >= NS_HALF) r_next.sec = r_reg.sec + 32'h1;
        r_next.gcnt = '0;
      end else if (r_reg.gcnt == GNSS_LOSS_CYC - 1) begin
        r_next.fsm = ST_HOLD;
        rv = 1'b1;
        rp = rpt_word(OP_RUN, SRC_LTE, 1'b1, 1'b0);
        set[IRQ_SRC] = 1'b1;
      end else begin
        r_next.gcnt = r_reg.gcnt + 1'b1;
      end
      default: r_next.fsm = ST_IDLE;
    endcase
    // Pulse generation, stamped at the rising edge
    if (fire) begin
      r_next.pout = 1'b1;
      r_next.pcnt = PULSE_CYC - 1'b1;
      r_next.ts_ns = adj_ns;
      r_next.ts_s = adj_s;
      if (r_reg.mode == MODE_SHOT) begin
        r_next.shot_arm = 1'b0;
        set[IRQ_TS] = 1'b1;
      end
    end else if (r_reg.pcnt != '0) begin
      r_next.pcnt = r_reg.pcnt - 1'b1;
    end else begin
      r_next.pout = 1'b0;
    end
    // External edge stamping
    if (running && r_reg.mode == MODE_EXT && ex_rise) begin
      r_next.ts_ns = adj_ns;
      r_next.ts_s = adj_s;
      set[IRQ_TS] = 1'b1;
    end
    // Bus write channels, taken in either order
    if (awvalid && r_reg.awrdy) begin
      r_next.awa = awaddr;
      r_next.aw_ok = 1'b1;
      r_next.awrdy = 1'b0;
    end
    if (wvalid && r_reg.wrdy) begin
      r_next.wd = wdata;
      r_next.ws = wstrb;
      r_next.w_ok = 1'b1;
      r_next.wrdy = 1'b0;
    end
    if (wr_go) begin
      r_next.aw_ok = 1'b0;
      r_next.w_ok = 1'b0;
      r_next.bvld = 1'b1;
      r_next.bresp = RESP_OK;
      case (r_reg.awa)
        REG_CTRL: begin
          m = wmerge({27'h0, r_reg.sten, 2'h0, r_reg.mode}, r_reg.wd, r_reg.ws);
          r_next.sten = m[CTRL_STEN];
          r_next.mode = m[1:0];
          r_next.shot_arm = (m[1:0] == MODE_SHOT);
          rv = 1'b1;
          if (m[1:0] == MODE_OFF) begin
            r_next.fsm = ST_IDLE;
            r_next.pout = 1'b0;
            r_next.pcnt = '0;
            rp = rpt_word(OP_OFF, SRC_STOP, 1'b1, 1'b0);
          end else if (r_reg.fsm == ST_IDLE) begin
            r_next.fsm = ST_INIT;
            rp = rpt_word({1'b0, m[1:0]}, SRC_NONE, 1'b0, 1'b0);
          end else begin
            rv = 1'b0;
          end
        end
        REG_OFF_NS: begin
          m = wmerge({2'h0, r_reg.off_ns}, r_reg.wd, r_reg.ws);
          if (m[29:0] < NS_PER_SEC) r_next.off_ns = m[29:0];
          else r_next.bresp = RESP_ERR;
        end
        REG_OFF_S: r_next.off_s = wmerge(r_reg.off_s, r_reg.wd, r_reg.ws);
        REG_ISTAT: r_next.ist = r_reg.ist & ~r_reg.wd[2:0] & {3{r_reg.ws[0]}} |
                                r_reg.ist & {3{~r_reg.ws[0]}};
        REG_IMASK: if (r_reg.ws[0]) r_next.imask = r_reg.wd[2:0];
        REG_RPT, REG_DISC, REG_TS_S, REG_TS_NS: begin
        end
        default: r_next.bresp = RESP_ERR;
      endcase
    end
    if (r_reg.bvld && bready) begin
      r_next.bvld = 1'b0;
      r_next.awrdy = 1'b1;
      r_next.wrdy = 1'b1;
    end
    // Bus read channel
    if (arvalid && r_reg.arrdy) begin
      r_next.arrdy = 1'b0;
      r_next.rvld = 1'b1;
      r_next.rresp = RESP_OK;
      case (araddr)
        REG_CTRL:   r_next.rdata = {27'h0, r_reg.sten, 2'h0, r_reg.mode};
        REG_OFF_NS: r_next.rdata = {2'h0, r_reg.off_ns};
        REG_OFF_S:  r_next.rdata = r_reg.off_s;
        REG_RPT:    r_next.rdata = r_reg.rpt;
        REG_DISC:   r_next.rdata = {2'h0, r_reg.disc};
        REG_TS_S:   r_next.rdata = r_reg.ts_s;
        REG_TS_NS:  r_next.rdata = {2'h0, r_reg.ts_ns};
        REG_ISTAT:  r_next.rdata = {29'h0, r_reg.ist};
        REG_IMASK:  r_next.rdata = {29'h0, r_reg.imask};
        default: begin
          r_next.rdata = '0;
          r_next.rresp = RESP_ERR;
        end
      endcase
    end
    if (r_reg.rvld && rready) begin
      r_next.rvld = 1'b0;
      r_next.arrdy = 1'b1;
    end
    // Reports are gated by the enable; a new event beats a clear
    if (rv && r_next.sten) begin
      r_next.rpt = rp;
      set[IRQ_RPT] = 1'b1;
    end
    r_next.ist = r_next.ist | set;
    r_next.irq = |(r_next.ist & r_next.imask);
  end

  // ******************************
  // Registers
  // ******************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.awrdy <= 1'b1;
      r_reg.wrdy <= 1'b1;
      r_reg.arrdy <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign awready   = r_reg.awrdy;
  assign wready    = r_reg.wrdy;
  assign bvalid    = r_reg.bvld;
  assign bresp     = r_reg.bresp;
  assign arready   = r_reg.arrdy;
  assign rvalid    = r_reg.rvld;
  assign rdata     = r_reg.rdata;
  assign rresp     = r_reg.rresp;
  assign pulse_out = r_reg.pout;
  assign irq       = r_reg.irq;

  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_align;
    r_reg.fsm == ST_LOCAL && gp_rise && !wr_go;
  endsequence
  sequence s_utc_steps;
    r_reg.fsm == ST_DISC ##1 r_reg.fsm == ST_UTC;
  endsequence
  a_utc_align: assert property (s_align |=> s_utc_steps)
    else $error("utc alignment steps wrong");
  a_lte_local: assert property (r_reg.fsm == ST_INIT && r_reg.ll[3] && !wr_go
    |=> r_reg.fsm == ST_LOCAL && r_reg.ist[IRQ_SRC])
    else $error("lte lock not taken");
  a_gnss_loss: assert property (r_reg.fsm == ST_UTC && !gp_rise && !wr_go &&
    r_reg.gcnt == GNSS_LOSS_CYC - 1 |=> r_reg.fsm == ST_HOLD)
    else $error("no fallback on gnss loss");
  a_stop_off: assert property (wr_go && r_reg.awa == REG_CTRL && r_reg.ws[0] &&
    r_reg.wd[1:0] == MODE_OFF |=> r_reg.fsm == ST_IDLE && !pulse_out)
    else $error("stop did not end timing");
  a_init_code: assert property (wr_go && r_reg.awa == REG_CTRL && r_reg.ws[0] &&
    r_reg.wd[1:0] != MODE_OFF && r_reg.fsm == ST_IDLE |=> r_reg.fsm == ST_INIT &&
    (!r_reg.sten || r_reg.rpt[2:0] == {1'b0, $past(r_reg.wd[1:0])}))
    else $error("bad init report");
  a_rpt_gate: assert property ($changed(r_reg.rpt) |-> r_reg.sten)
    else $error("report without enable");
  a_pulse_wide: assert property ($rose(pulse_out) |-> pulse_out [*8])
    else $error("pulse too short");
  a_stamp_edge: assert property (fire |=> pulse_out &&
    r_reg.ts_ns == $past(adj_ns))
    else $error("stamp not at rising edge");
  a_irq_level: assert property (irq == |(r_reg.ist & r_reg.imask))
    else $error("irq level mismatch");
endmodule : time_pulse_stamper

// file: src/stamper_pkg.sv
// Purpose: constants, types and helpers of the time pulse stamper
// Assumes: 40 MHz clock, 32-bit AXI4-Lite register bus
// Notes:   counts derived from times in their own unit
package stamper_pkg;
  // ******************************
  // Timing
  // ******************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_W_MS    = 100;
  localparam int GNSS_LOSS_MS  = 1500;
  localparam int GCNT_W        = 26;
  localparam int PCNT_W        = 22;
  localparam longint PULSE_CYC_DEF =
    (longint'(PULSE_W_MS) * 1000000) / CLK_PERIOD_NS;
  localparam longint GNSS_LOSS_DEF =
    (longint'(GNSS_LOSS_MS) * 1000000) / CLK_PERIOD_NS;
  localparam logic [29:0] NS_PER_SEC = 30'h3b9aca00;
  localparam logic [29:0] NS_HALF    = 30'h1dcd6500;
  localparam logic [29:0] NS_STEP    = 30'(CLK_PERIOD_NS);
  // ******************************
  // Register map
  // ******************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_OFF_NS = 8'h04;
  localparam logic [7:0] REG_OFF_S  = 8'h08;
  localparam logic [7:0] REG_RPT    = 8'h0c;
  localparam logic [7:0] REG_DISC   = 8'h10;
  localparam logic [7:0] REG_TS_S   = 8'h14;
  localparam logic [7:0] REG_TS_NS  = 8'h18;
  localparam logic [7:0] REG_ISTAT  = 8'h1c;
  localparam logic [7:0] REG_IMASK  = 8'h20;
  localparam int CTRL_STEN = 4;
  localparam int IRQ_RPT = 0;
  localparam int IRQ_TS  = 1;
  localparam int IRQ_SRC = 2;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ******************************
  // Modes and report codes
  // ******************************
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_PPS  = 2'h1;
  localparam logic [1:0] MODE_SHOT = 2'h2;
  localparam logic [1:0] MODE_EXT  = 2'h3;
  localparam logic [2:0] OP_OFF = 3'h0;
  localparam logic [2:0] OP_RUN = 3'h4;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_GNSS = 2'h1;
  localparam logic [1:0] SRC_LTE  = 2'h2;
  localparam logic [1:0] SRC_STOP = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_INIT  = 3'h1,
    ST_LOCAL = 3'h2,
    ST_DISC  = 3'h3,
    ST_UTC   = 3'h4,
    ST_HOLD  = 3'h5
  } state_t;
  // Report word: op[2:0], source[5:4], utc[8], result[12]
  function automatic logic [31:0] rpt_word(logic [2:0] op, logic [1:0] src,
                                           logic utc, logic res);
    rpt_word = {19'h0, res, 3'h0, utc, 2'h0, src, 1'h0, op};
  endfunction : rpt_word
  // Byte-lane merge of a bus write
  function automatic logic [31:0] wmerge(logic [31:0] o, logic [31:0] d,
                                         logic [3:0] s);
    wmerge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) wmerge[8*i +: 8] = d[8*i +: 8];
    end
  endfunction : wmerge
  // Pin synchroniser: [0..2] flops, [3] filtered level
  function automatic logic [3:0] sync3(logic [3:0] s, logic pin);
    sync3 = {(s[1] == s[2]) ? s[2] : s[3], s[1], s[0], pin};
  endfunction : sync3
endpackage : stamper_pkg

// file: verif/time_source_model.sv
// Purpose: stand-in for the lock level, navigation pulses and event pin
// Assumes: controls change just after a rising clock edge
// Notes:   navigation pulse every GAP cycles, four cycles high
`timescale 1ns/1ps
module time_source_model #(
  parameter int GAP = 100
) (
  input  wire logic clk,
  input  wire logic lock_on,
  input  wire logic gnss_on,
  input  wire logic ext_fire,
  output logic      lte_lock = 1'b0,
  output logic      gnss_pulse = 1'b0,
  output logic      ext_edge = 1'b0
);
  // ******************************
  // Sources
  // ******************************
  int cnt = 0;
  int ecnt = 0;
  // Pins idle low between pulses, as a real pulse line rests
  always @(posedge clk) begin
    lte_lock   <= lock_on;
    cnt        <= gnss_on ? ((cnt == GAP - 1) ? 0 : cnt + 1) : 0;
    gnss_pulse <= gnss_on && (cnt < 4);
    ecnt       <= ext_fire ? 8 : ((ecnt > 0) ? ecnt - 1 : 0);
    ext_edge   <= (ecnt > 0);
  end
endmodule : time_source_model

// file: verif/time_pulse_stamper_tb.sv
// Purpose: self-checking bench of the time pulse stamper
// Assumes: one AXI4-Lite access at a time, short pulse and loss counts
// Notes:   offset puts the whole-second point 3000 cycles after a snap
`timescale 1ns/1ps
module time_pulse_stamper_tb;
  import stamper_pkg::*;
  // ******************************
  // Signals
  // ******************************
  logic        clk = 1'b0, rst_b = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, pulse_out, irq;
  logic        gnss_pulse, lte_lock, ext_edge;
  logic        lock_on = 1'b0, gnss_on = 1'b0, ext_fire = 1'b0;
  int          error_cnt = 0, n_checks = 0;
  localparam logic [31:0] OFF = 32'(NS_PER_SEC) - 32'd75000;

  always #12.5 clk = ~clk;

  time_pulse_stamper #(.PULSE_CYC(22'd16), .GNSS_LOSS_CYC(26'd200)) i_time_pulse_stamper (
    .clk, .rst_b, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .gnss_pulse, .lte_lock, .ext_edge, .pulse_out, .irq
  );
  time_source_model i_time_source_model (
    .clk, .lock_on, .gnss_on, .ext_fire, .lte_lock, .gnss_pulse, .ext_edge
  );
  // ******************************
  // Tasks
  // ******************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Address and data offered together, each dropped once taken
  // No cycle count is assumed; only the watchdog ends a stuck wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    d = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd
  task automatic rck(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, RESP_OK, d);
    chk(d, exp);
  endtask : rck
  // Waits for a pulse, then counts its high cycles and checks its stamp
  task automatic pulse_chk();
    int i;
    int w;
    logic [31:0] d;
    w = 0;
    for (i = 0; i < 4000 && !pulse_out; i++) @(posedge clk);
    while (pulse_out && w < 100) begin
      w++;
      @(posedge clk);
    end
    chk(w, 32'd16);
    rd(REG_TS_NS, RESP_OK, d);
    chk({31'h0, d < 32'd25}, 32'h1);
  endtask : pulse_chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // ******************************
  // Tests
  // ******************************
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rck(REG_CTRL, 32'h0);
    rck(REG_RPT, 32'h0);
    rck(REG_ISTAT, 32'h0);
    rd(8'h24, RESP_ERR, rv);
    chk(rv, 32'h0);
    wr(8'h24, 32'h0, RESP_ERR);
    wr(REG_OFF_NS, 32'(NS_PER_SEC), RESP_ERR);
    rck(REG_OFF_NS, 32'h0);
    wr(REG_OFF_NS, OFF, RESP_OK);
    rck(REG_OFF_NS, OFF);
    // Reports stay silent while the enable is clear
    lock_on <= 1'b1;
    wr(REG_CTRL, 32'h1, RESP_OK);
    repeat (20) @(posedge clk);
    rck(REG_RPT, 32'h0);
    wr(REG_CTRL, 32'h0, RESP_OK);
    lock_on <= 1'b0;
    wr(REG_ISTAT, 32'h7, RESP_OK);
    // Pulse mode with reports and an unmasked report interrupt
    wr(REG_IMASK, 32'h1, RESP_OK);
    // Enable rides in the start write; pin and start instant are fixed here
    wr(REG_CTRL, 32'h11, RESP_OK);
    rck(REG_RPT, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(REG_ISTAT, 32'h7, RESP_OK);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    lock_on <= 1'b1;
    repeat (20) @(posedge clk);
    rck(REG_RPT, 32'h24);
    rd(REG_ISTAT, RESP_OK, rv);
    chk(rv & 32'h5, 32'h5);
    chk({31'h0, irq}, 32'h1);
    wr(REG_IMASK, 32'h0, RESP_OK);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(REG_ISTAT, 32'h7, RESP_OK);
    // Navigation pulses align to UTC, then their loss falls back
    gnss_on <= 1'b1;
    repeat (150) @(posedge clk);
    rck(REG_RPT, 32'h1114);
    rd(REG_ISTAT, RESP_OK, rv);
    chk(rv & 32'h4, 32'h4);
    rd(REG_DISC, RESP_OK, rv);
    chk({31'h0, rv != 32'h0}, 32'h1);
    gnss_on <= 1'b0;
    repeat (300) @(posedge clk);
    rck(REG_RPT, 32'h124);
    pulse_chk();
    // Lock dropped, so the next start stays in its init step
    lock_on <= 1'b0;
    wr(REG_CTRL, 32'h10, RESP_OK);
    rck(REG_RPT, 32'h130);
    // Single stamped pulse after a fresh navigation snap
    wr(REG_CTRL, 32'h12, RESP_OK);
    rck(REG_RPT, 32'h2);
    lock_on <= 1'b1;
    repeat (20) @(posedge clk);
    rck(REG_RPT, 32'h24);
    wr(REG_ISTAT, 32'h7, RESP_OK);
    gnss_on <= 1'b1;
    repeat (50) @(posedge clk);
    gnss_on <= 1'b0;
    pulse_chk();
    rd(REG_ISTAT, RESP_OK, rv);
    chk({31'h0, rv[1]}, 32'h1);
    // External edge stamping
    lock_on <= 1'b0;
    wr(REG_CTRL, 32'h10, RESP_OK);
    wr(REG_CTRL, 32'h13, RESP_OK);
    rck(REG_RPT, 32'h3);
    lock_on <= 1'b1;
    repeat (20) @(posedge clk);
    wr(REG_ISTAT, 32'h7, RESP_OK);
    ext_fire <= 1'b1;
    @(posedge clk);
    ext_fire <= 1'b0;
    repeat (20) @(posedge clk);
    rd(REG_ISTAT, RESP_OK, rv);
    chk({31'h0, rv[1]}, 32'h1);
    wr(REG_OFF_S, 32'h3c, RESP_OK);
    rck(REG_OFF_S, 32'h3c);
    // Zero in both parts clears the offset
    wr(REG_OFF_NS, 32'h0, RESP_OK);
    wr(REG_OFF_S, 32'h0, RESP_OK);
    rck(REG_OFF_NS, 32'h0);
    rck(REG_OFF_S, 32'h0);
    end_of_test();
  end
  // Run should take about 6500 cycles; a hang ends it as a failure
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule : time_pulse_stamper_tb
